// file: hw/imager_cfg_pkg.sv
package imager_cfg_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_RAMP = 8'hCD;
  localparam logic [7:0] ADDR_FILTER = 8'hDF;
  localparam logic [7:0] ADDR_TOFS = 8'hE8;
  localparam logic [7:0] ADDR_TSLP = 8'hE9;
  localparam logic [7:0] ADDR_SCR1 = 8'hF0;
  localparam logic [7:0] ADDR_SCR2 = 8'hF1;
  localparam logic [7:0] ADDR_CUST = 8'hF5;
  localparam logic [7:0] ADDR_WAF_HI = 8'hF6;
  localparam logic [7:0] ADDR_WAF_LO = 8'hF7;
  localparam logic [7:0] ADDR_DIE_HI = 8'hF8;
  localparam logic [7:0] ADDR_DIE_LO = 8'hF9;
  localparam logic [7:0] ADDR_KIND = 8'hFA;
  localparam logic [7:0] ADDR_REV = 8'hFB;

  // ----------------------------------------
  // field positions and writable masks
  // ----------------------------------------
  localparam int FINE_LSB = 0;
  localparam int SKIP_BIT = 3;
  localparam int RES_SEL_BIT = 4;
  localparam int PULSE_LSB = 0;
  localparam int FRAME_LSB = 4;
  localparam logic [7:0] RAMP_WMASK = 8'h1B;
  localparam logic [7:0] FILTER_WMASK = 8'h77;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RAMP_RST = 8'h13;
  localparam logic [7:0] FILTER_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'hFF;
  localparam logic [7:0] SCRATCH_RST = 8'h00;

  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_FULL_NS = 15750;
  localparam int CONV_MIN_NS = 12250;
  localparam int CONV_STEP_NS = 875;
  localparam int SIGN_SKIP_NS = 875;
  localparam logic [3:0] FULL_BITS = 4'hC;
  localparam logic [3:0] MIN_BITS = 4'h8;
  localparam logic [3:0] PULSE_SHIFT_BASE = 4'h2;
  localparam logic [3:0] PULSE_SHIFT_MAX = 4'h8;

  // least time, rounded up to whole clock cycles
  function automatic logic [11:0] ns_to_cyc(input int ns);
    return 12'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  localparam logic [11:0] CONV_FULL_CYC = ns_to_cyc(CONV_FULL_NS);
  // reduced conversions, indexed by {fine, skip}
  localparam logic [11:0] CONV_CYC [8] = '{
    ns_to_cyc(CONV_MIN_NS),
    ns_to_cyc(CONV_MIN_NS + SIGN_SKIP_NS),
    ns_to_cyc(CONV_MIN_NS + CONV_STEP_NS),
    ns_to_cyc(CONV_MIN_NS + CONV_STEP_NS + SIGN_SKIP_NS),
    ns_to_cyc(CONV_MIN_NS + 2 * CONV_STEP_NS),
    ns_to_cyc(CONV_MIN_NS + 2 * CONV_STEP_NS + SIGN_SKIP_NS),
    ns_to_cyc(CONV_MIN_NS + 3 * CONV_STEP_NS),
    ns_to_cyc(CONV_MIN_NS + 3 * CONV_STEP_NS + SIGN_SKIP_NS)
  };

endpackage

// file: hw/avg_if.sv
`timescale 1ns/1ns
// strobe, sample and weight into one averaging filter, average back out
interface avg_if #(parameter int W = 8);
  logic strobe;
  logic [W-1:0] sample;
  logic [3:0] shift;
  logic [W-1:0] avg;
  modport core (input strobe, input sample, input shift, output avg);
  modport user (output strobe, output sample, output shift, input avg);
endinterface

// file: hw/avg_filter.sv
`timescale 1ns/1ns
module avg_filter
  import imager_cfg_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // filter port
  avg_if.core bus
);

  logic [W-1:0] avg_reg;
  logic [W-1:0] avg_next;
  logic signed [W:0] diff;
  logic signed [W:0] step;

  // ----------------------------------------
  // weighted average step
  // ----------------------------------------
  // avg moves by (sample - avg) / 2^shift, never overshooting
  always_comb begin
    diff = $signed({1'b0, bus.sample}) - $signed({1'b0, avg_reg});
    step = diff >>> bus.shift;
    avg_next = avg_reg;
    if (bus.strobe) begin
      avg_next = avg_reg + step[W-1:0];
    end
  end

  // average register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      avg_reg <= '0;
    end else begin
      avg_reg <= avg_next;
    end
  end

  assign bus.avg = avg_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  half_weight_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    bus.strobe && bus.shift == 4'h1 && bus.sample > avg_reg
    |=> avg_reg == $past(avg_reg) + (($past(bus.sample) - $past(avg_reg)) >> 1))
    else $error("half weight step wrong");

  toward_sample_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    bus.strobe && bus.shift != 4'h0 && bus.sample > avg_reg
    |=> avg_reg <= $past(bus.sample) && avg_reg >= $past(avg_reg))
    else $error("average left the range between old value and sample");

endmodule

// file: hw/imager_adc_dll_id_regs.sv
// Operation
// - resolution bit 0 gives 12-bit, 15.750 us
// - fine field picks 8..11 bits and duration
// - fine field used only when resolution bit set
// - sign skip adds one step, 0.875 us
// - skip, 8-bit format, fine 00 gives grayscale
// - sign skip effective only with resolution bit
// - frame filter averages match values, 000 off
// - pulse filter averages per pulse, 000 off
// - averages replace manual delay when loop off
// - external loop control suppresses both filters
// - offset trim byte stored for software
// - slope trim byte stored for software
// - wafer number read-only, high then low byte
// - die position and part bytes read-only
// - 8-bit format sends eight pixel msbs
`timescale 1ns/1ns
module imager_adc_dll_id_regs
  import imager_cfg_pkg::*;
#(
  parameter int DLL_W = 8,
  parameter logic [7:0] CUSTOMER_VAL = 8'h5A, // arbitrary value
  parameter logic [15:0] WAFER_VAL = 16'h1234, // arbitrary value
  parameter logic [15:0] DIE_VAL = 16'h0A0B, // arbitrary value
  parameter logic [7:0] KIND_VAL = 8'h3C, // arbitrary value
  parameter logic [7:0] REVISION_VAL = 8'h01 // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register access from the control slave
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // converter control
  input wire logic conv_start,
  output logic conv_busy,
  output logic conv_done,
  output logic [3:0] conv_bits,
  output logic sign_skip_active,
  // pixel output path
  input wire logic tcmi_8bit_mode,
  input wire logic [11:0] pix_code,
  input wire logic pix_valid,
  output logic [7:0] pix_byte,
  output logic pix_byte_valid,
  output logic gray_unsigned,
  // delay locked loop
  input wire logic dll_enable,
  input wire logic dll_ctrl_ext,
  input wire logic [DLL_W-1:0] dll_match,
  input wire logic mod_pulse,
  input wire logic frame_end,
  input wire logic [DLL_W-1:0] manual_delay,
  output logic [DLL_W-1:0] delay_ctrl
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] ramp_reg, ramp_next;
  logic [7:0] filter_reg, filter_next;
  logic [7:0] tofs_reg, tofs_next;
  logic [7:0] tslp_reg, tslp_next;
  logic [7:0] scr1_reg, scr1_next;
  logic [7:0] scr2_reg, scr2_next;
  logic [7:0] rdata_reg, rdata_next;

  logic res_sel;
  logic skip_en;
  logic [1:0] fine_sel;
  logic [2:0] frame_avg_weight;
  logic [2:0] pulse_avg_weight;

  // field views of the configuration bytes
  assign res_sel = ramp_reg[RES_SEL_BIT];
  assign skip_en = ramp_reg[SKIP_BIT];
  assign fine_sel = ramp_reg[FINE_LSB +: 2];
  assign frame_avg_weight = filter_reg[FRAME_LSB +: 3];
  assign pulse_avg_weight = filter_reg[PULSE_LSB +: 3];

  // writes store only defined bits, id bytes take none
  always_comb begin
    ramp_next = ramp_reg;
    filter_next = filter_reg;
    tofs_next = tofs_reg;
    tslp_next = tslp_reg;
    scr1_next = scr1_reg;
    scr2_next = scr2_reg;
    if (reg_wr) begin
      if (reg_addr == ADDR_RAMP) begin
        ramp_next = reg_wdata & RAMP_WMASK;
      end else if (reg_addr == ADDR_FILTER) begin
        filter_next = reg_wdata & FILTER_WMASK;
      end else if (reg_addr == ADDR_TOFS) begin
        tofs_next = reg_wdata;
      end else if (reg_addr == ADDR_TSLP) begin
        tslp_next = reg_wdata;
      end else if (reg_addr == ADDR_SCR1) begin
        scr1_next = reg_wdata;
      end else if (reg_addr == ADDR_SCR2) begin
        scr2_next = reg_wdata;
      end
    end
  end

  // read mux, answer held until the next read
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (reg_addr == ADDR_RAMP) begin
        rdata_next = ramp_reg;
      end else if (reg_addr == ADDR_FILTER) begin
        rdata_next = filter_reg;
      end else if (reg_addr == ADDR_TOFS) begin
        rdata_next = tofs_reg;
      end else if (reg_addr == ADDR_TSLP) begin
        rdata_next = tslp_reg;
      end else if (reg_addr == ADDR_SCR1) begin
        rdata_next = scr1_reg;
      end else if (reg_addr == ADDR_SCR2) begin
        rdata_next = scr2_reg;
      end else if (reg_addr == ADDR_CUST) begin
        rdata_next = CUSTOMER_VAL;
      end else if (reg_addr == ADDR_WAF_HI) begin
        rdata_next = WAFER_VAL[15:8];
      end else if (reg_addr == ADDR_WAF_LO) begin
        rdata_next = WAFER_VAL[7:0];
      end else if (reg_addr == ADDR_DIE_HI) begin
        rdata_next = DIE_VAL[15:8];
      end else if (reg_addr == ADDR_DIE_LO) begin
        rdata_next = DIE_VAL[7:0];
      end else if (reg_addr == ADDR_KIND) begin
        rdata_next = KIND_VAL;
      end else if (reg_addr == ADDR_REV) begin
        rdata_next = REVISION_VAL;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // register file flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ramp_reg <= RAMP_RST;
      filter_reg <= FILTER_RST;
      tofs_reg <= TRIM_RST;
      tslp_reg <= TRIM_RST;
      scr1_reg <= SCRATCH_RST;
      scr2_reg <= SCRATCH_RST;
      rdata_reg <= 8'h00;
    end else begin
      ramp_reg <= ramp_next;
      filter_reg <= filter_next;
      tofs_reg <= tofs_next;
      tslp_reg <= tslp_next;
      scr1_reg <= scr1_next;
      scr2_reg <= scr2_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // conversion timer
  // ----------------------------------------
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [11:0] cnt_reg, cnt_next;
  logic [3:0] bits_reg, bits_next;
  logic skip_act_reg, skip_act_next;

  // settings latched at start, start ignored while busy
  always_comb begin
    busy_next = busy_reg;
    done_next = 1'b0;
    cnt_next = cnt_reg;
    bits_next = bits_reg;
    skip_act_next = skip_act_reg;
    if (busy_reg) begin
      if (cnt_reg == 12'h000) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 12'h001;
      end
    end else if (conv_start) begin
      busy_next = 1'b1;
      if (res_sel) begin
        bits_next = MIN_BITS + {2'b00, fine_sel};
        skip_act_next = skip_en;
        cnt_next = CONV_CYC[{fine_sel, skip_en}] - 12'h001;
      end else begin
        bits_next = FULL_BITS;
        skip_act_next = 1'b0;
        cnt_next = CONV_FULL_CYC - 12'h001;
      end
    end
  end

  // conversion timer flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 12'h000;
      bits_reg <= FULL_BITS;
      skip_act_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      cnt_reg <= cnt_next;
      bits_reg <= bits_next;
      skip_act_reg <= skip_act_next;
    end
  end

  assign conv_busy = busy_reg;
  assign conv_done = done_reg;
  assign conv_bits = bits_reg;
  assign sign_skip_active = skip_act_reg;

  // ----------------------------------------
  // pixel output path
  // ----------------------------------------
  logic [7:0] pbyte_reg, pbyte_next;
  logic pvalid_reg, pvalid_next;
  logic gray_reg, gray_next;

  // eight msbs per pixel, one beat each
  always_comb begin
    pbyte_next = pbyte_reg;
    pvalid_next = pix_valid & tcmi_8bit_mode;
    if (pix_valid) begin
      pbyte_next = pix_code[11:4];
    end
    gray_next = res_sel & skip_en & tcmi_8bit_mode & (fine_sel == 2'b00);
  end

  // pixel path flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pbyte_reg <= 8'h00;
      pvalid_reg <= 1'b0;
      gray_reg <= 1'b0;
    end else begin
      pbyte_reg <= pbyte_next;
      pvalid_reg <= pvalid_next;
      gray_reg <= gray_next;
    end
  end

  assign pix_byte = pbyte_reg;
  assign pix_byte_valid = pvalid_reg;
  assign gray_unsigned = gray_reg;

  // ----------------------------------------
  // match value averaging
  // ----------------------------------------
  // index 0 runs per frame, index 1 per modulation pulse
  logic [1:0] flt_on;
  logic [1:0] flt_tick;
  logic [3:0] flt_shift [2];
  logic [DLL_W-1:0] flt_avg [2];
  logic [DLL_W-1:0] delay_reg, delay_next;

  // filters idle while externally controlled
  always_comb begin
    flt_on[0] = (frame_avg_weight != 3'b000) & ~dll_ctrl_ext;
    flt_on[1] = (pulse_avg_weight != 3'b000) & ~dll_ctrl_ext;
    flt_tick[0] = frame_end & flt_on[0];
    flt_tick[1] = mod_pulse & flt_on[1];
    flt_shift[0] = {1'b0, frame_avg_weight};
    if (pulse_avg_weight >= 3'b110) begin
      flt_shift[1] = PULSE_SHIFT_MAX;
    end else begin
      flt_shift[1] = {1'b0, pulse_avg_weight} + PULSE_SHIFT_BASE;
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_flt
      avg_if #(.W(DLL_W)) flt_bus ();
      assign flt_bus.strobe = flt_tick[i];
      assign flt_bus.sample = dll_match;
      assign flt_bus.shift = flt_shift[i];
      assign flt_avg[i] = flt_bus.avg;
      avg_filter #(.W(DLL_W)) u_flt (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .bus(flt_bus.core)
      );
    end
  endgenerate

  // live match while locked, else average, else manual value
  always_comb begin
    if (dll_enable) begin
      delay_next = dll_match;
    end else if (flt_on[0]) begin
      delay_next = flt_avg[0];
    end else if (flt_on[1]) begin
      delay_next = flt_avg[1];
    end else begin
      delay_next = manual_delay;
    end
  end

  // delay output flop
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      delay_reg <= '0;
    end else begin
      delay_reg <= delay_next;
    end
  end

  assign delay_ctrl = delay_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int FULL_LEN = 1575;
  localparam int SKIP8_LEN = 1313;
  logic [11:0] len_reg;

  // busy length counter for the timing checks
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      len_reg <= 12'h000;
    end else begin
      len_reg <= busy_reg ? len_reg + 12'h001 : 12'h000;
    end
  end

  full_conv_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done_reg && bits_reg == FULL_BITS |-> len_reg == 12'(FULL_LEN))
    else $error("full conversion length wrong");

  fine_width_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_start && !busy_reg && res_sel |=> bits_reg == MIN_BITS + {2'b00, $past(fine_sel)})
    else $error("reduced width does not follow fine field");

  fine_ignored_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_start && !busy_reg && !res_sel |=> bits_reg == FULL_BITS && busy_reg)
    else $error("fine field affected a full conversion");

  skip_extend_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    done_reg && skip_act_reg && bits_reg == MIN_BITS |-> len_reg == 12'(SKIP8_LEN))
    else $error("sign skip step length wrong");

  gray_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    res_sel && skip_en && tcmi_8bit_mode && fine_sel == 2'b00 |=> gray_reg)
    else $error("grayscale mode not flagged");

  skip_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    conv_start && !busy_reg && !res_sel |=> !skip_act_reg ##1 !skip_act_reg)
    else $error("sign skip active without reduced resolution");

  avg_override_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !dll_enable && flt_on[0] |=> delay_reg == $past(flt_avg[0]))
    else $error("frame average did not drive the delay");

  ext_suppress_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dll_ctrl_ext && !dll_enable |=> delay_reg == $past(manual_delay))
    else $error("filter active under external control");

  wafer_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_WAF_HI |=> rdata_reg == WAFER_VAL[15:8])
    else $error("wafer high byte misread");

  scratch_back_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_wr && reg_addr == ADDR_SCR1 ##1 !reg_wr ##1 reg_rd && reg_addr == ADDR_SCR1 && !reg_wr
    |=> rdata_reg == $past(reg_wdata, 3))
    else $error("scratch byte did not read back");

  pix_msb_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pix_valid && tcmi_8bit_mode |=> pvalid_reg && pbyte_reg == $past(pix_code[11:4]))
    else $error("pixel byte is not the eight msbs");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_FILTER |=> rdata_reg[7] == 1'b0 && rdata_reg[3] == 1'b0)
    else $error("reserved filter bits read nonzero");

endmodule

// file: sim/host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host side of the register port
// ----------------------------------------
module host_model (
  // clock
  input wire logic clk_sys,
  // register access
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one write strobe; released lines show inverted values
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask

  // one read strobe; answer taken once the read edge has landed
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    #1;
    data = reg_rdata;
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import imager_cfg_pkg::*;
();
  // ----------------------------------------
  // signals and identity values
  // ----------------------------------------
  localparam logic [7:0] CUST_V = 8'hC3; // arbitrary value
  localparam logic [15:0] WAF_V = 16'h6E29; // arbitrary value
  localparam logic [15:0] DIE_V = 16'h0457; // arbitrary value
  localparam logic [7:0] KIND_V = 8'h2D; // arbitrary value
  localparam logic [7:0] REV_V = 8'h07; // arbitrary value
  logic clk_sys, sys_rst, reg_wr, reg_rd, conv_start, conv_busy, conv_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pix_byte, dll_match, manual_delay, delay_ctrl;
  logic [3:0] conv_bits;
  logic [11:0] pix_code;
  logic sign_skip_active, tcmi_8bit_mode, pix_valid, pix_byte_valid, gray_unsigned;
  logic dll_enable, dll_ctrl_ext, mod_pulse, frame_end;
  logic [7:0] d;
  int num_errors, checked, cnt, i;
  localparam logic [15:0] RST_TAB [14] = '{{ADDR_RAMP, 8'h13}, {ADDR_FILTER, 8'h00},
    {ADDR_TOFS, 8'hFF}, {ADDR_TSLP, 8'hFF}, {ADDR_SCR1, 8'h00}, {ADDR_SCR2, 8'h00},
    {ADDR_CUST, CUST_V}, {ADDR_WAF_HI, WAF_V[15:8]}, {ADDR_WAF_LO, WAF_V[7:0]},
    {ADDR_DIE_HI, DIE_V[15:8]}, {ADDR_DIE_LO, DIE_V[7:0]}, {ADDR_KIND, KIND_V},
    {ADDR_REV, REV_V}, 16'hE000};
  // address, write data, expected read back
  localparam logic [23:0] WR_TAB [11] = '{24'hCDFF1B, 24'hCDE400, 24'hDFFF77, 24'hDF8800,
    24'hE87F7F, 24'hE98080, 24'hF05A5A, 24'hF1A5A5, {ADDR_WAF_HI, 8'h00, WAF_V[15:8]},
    {ADDR_REV, 8'hFF, REV_V}, 24'hE0FF00};
  // busy cycles indexed by {fine, skip}
  localparam logic [10:0] CYC_TAB [8] = '{11'd1225, 11'd1313, 11'd1313, 11'd1400, 11'd1400,
    11'd1488, 11'd1488, 11'd1575};

  // ----------------------------------------
  // design, host and clock
  // ----------------------------------------
  imager_adc_dll_id_regs #(.DLL_W(8), .CUSTOMER_VAL(CUST_V), .WAFER_VAL(WAF_V),
    .DIE_VAL(DIE_V), .KIND_VAL(KIND_V), .REVISION_VAL(REV_V)) DUT (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_busy(conv_busy),
    .conv_done(conv_done), .conv_bits(conv_bits), .sign_skip_active(sign_skip_active),
    .tcmi_8bit_mode(tcmi_8bit_mode), .pix_code(pix_code), .pix_valid(pix_valid),
    .pix_byte(pix_byte), .pix_byte_valid(pix_byte_valid), .gray_unsigned(gray_unsigned),
    .dll_enable(dll_enable), .dll_ctrl_ext(dll_ctrl_ext), .dll_match(dll_match),
    .mod_pulse(mod_pulse), .frame_end(frame_end), .manual_delay(manual_delay),
    .delay_ctrl(delay_ctrl));
  host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // free running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // compare, report and conversion helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    host.read_reg(addr, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  // program ramp, start, count busy cycles under a bound
  task automatic run_conv(input logic [7:0] ramp, input logic [10:0] n,
      input logic [3:0] bits, input logic skip);
    host.write_reg(ADDR_RAMP, ramp);
    @(posedge clk_sys);
    conv_start <= 1'b1;
    @(posedge clk_sys);
    conv_start <= 1'b0;
    cnt = 0;
    #1;
    while (conv_busy === 1'b1 && cnt < 2000) begin
      cnt++;
      @(posedge clk_sys);
      #1;
    end
    if (cnt >= 2000) begin
      num_errors++;
      print_verdict();
    end
    check(16'(cnt), {5'h00, n});
    check({15'h0000, conv_done}, 16'h0001);
    check({12'h000, conv_bits}, {12'h000, bits});
    check({15'h0000, sign_skip_active}, {15'h0000, skip});
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    conv_start = 1'b0;
    tcmi_8bit_mode = 1'b0;
    pix_code = 12'h000;
    pix_valid = 1'b0;
    dll_enable = 1'b0;
    dll_ctrl_ext = 1'b0;
    dll_match = 8'h40;
    mod_pulse = 1'b0;
    frame_end = 1'b0;
    manual_delay = 8'h11;
    num_errors = 0;
    checked = 0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (i = 0; i < 14; i++) begin
      rd_chk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    end
    $display("test reset values done");
    for (i = 0; i < 11; i++) begin
      host.write_reg(WR_TAB[i][23:16], WR_TAB[i][15:8]);
      rd_chk(WR_TAB[i][23:16], WR_TAB[i][7:0]);
    end
    $display("test register access done");
    run_conv(8'h00, 11'd1575, 4'hC, 1'b0);
    run_conv(8'h0B, 11'd1575, 4'hC, 1'b0);
    for (i = 0; i < 8; i++) begin
      run_conv(8'h10 | {4'h0, i[0], 1'b0, i[2:1]}, CYC_TAB[i], 4'h8 + 4'(i[2:1]), i[0]);
    end
    $display("test conversion timing done");
    @(posedge clk_sys);
    tcmi_8bit_mode <= 1'b1;
    host.write_reg(ADDR_RAMP, 8'h18);
    repeat (3) @(posedge clk_sys);
    #1;
    check({15'h0000, gray_unsigned}, 16'h0001);
    @(posedge clk_sys);
    pix_valid <= 1'b1;
    pix_code <= 12'hABC;
    @(posedge clk_sys);
    pix_valid <= 1'b0;
    #1;
    check({pix_byte_valid, 7'h00, pix_byte}, 16'h80AB);
    host.write_reg(ADDR_RAMP, 8'h19);
    tcmi_8bit_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check({15'h0000, gray_unsigned}, 16'h0000);
    $display("test pixel path done");
    host.write_reg(ADDR_FILTER, 8'h10);
    repeat (3) @(posedge clk_sys);
    #1;
    check({8'h00, delay_ctrl}, 16'h0000);
    @(posedge clk_sys);
    frame_end <= 1'b1;
    @(posedge clk_sys);
    frame_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({8'h00, delay_ctrl}, 16'h0020);
    // external control: manual value out, frame average frozen
    @(posedge clk_sys);
    dll_ctrl_ext <= 1'b1;
    frame_end <= 1'b1;
    @(posedge clk_sys);
    frame_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({8'h00, delay_ctrl}, 16'h0011);
    @(posedge clk_sys);
    dll_ctrl_ext <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({8'h00, delay_ctrl}, 16'h0020);
    host.write_reg(ADDR_FILTER, 8'h01);
    @(posedge clk_sys);
    mod_pulse <= 1'b1;
    @(posedge clk_sys);
    mod_pulse <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({8'h00, delay_ctrl}, 16'h0008);
    host.write_reg(ADDR_FILTER, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1;
    check({8'h00, delay_ctrl}, 16'h0011);
    @(posedge clk_sys);
    dll_enable <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check({8'h00, delay_ctrl}, 16'h0040);
    $display("test delay loop filters done");
    print_verdict();
  end
endmodule
